// ==== logic/cafp_defs.svh ====
`ifndef CAFP_DEFS_SVH
`define CAFP_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CAFP_OFF_CTRL0     12'h000
`define CAFP_OFF_CTRL1     12'h004
`define CAFP_OFF_BT0       12'h008
`define CAFP_OFF_BT1       12'h00C
`define CAFP_OFF_RXFLAG    12'h010
`define CAFP_OFF_RXIEN     12'h014
`define CAFP_OFF_TXFLAG    12'h018
`define CAFP_OFF_TXIEN     12'h01C
`define CAFP_OFF_AFC       12'h020
`define CAFP_OFF_PATTERN   12'h024
`define CAFP_OFF_MASK      12'h028
`define CAFP_OFF_ERRCNT    12'h02C
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CAFP_CTRL0_SRL     0
`define CAFP_CTRL0_SLEEP_ACK   1
`define CAFP_RXF_FULL      0
`define CAFP_RXF_OVR       1
`define CAFP_RXF_BOFF      2
`define CAFP_RXF_TPASS     3
`define CAFP_RXF_RPASS     4
`define CAFP_RXF_TWARN     5
`define CAFP_RXF_RWARN     6
`define CAFP_RXF_WAKE      7
`define CAFP_AFC_MODE_LSB  4
`define CAFP_ERR_TEC_LSB   16
// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define CAFP_RST_CTRL0     8'h01
`define CAFP_RST_BYTE      8'h00
`define CAFP_RST_WORD      32'h0000_0000
`define CAFP_WARN_LIMIT    9'h060
`define CAFP_PASS_LIMIT    9'h07F
`define CAFP_BOFF_LIMIT    9'h0FF
`endif

// ==== logic/cafp_pkg.sv ====
package cafp_pkg;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CAFP_MODE_NORMAL = 2'b00,
    CAFP_MODE_SLEEP  = 2'b01,
    CAFP_MODE_SOFT   = 2'b10,
    CAFP_MODE_PDOWN  = 2'b11
  } cafp_mode_t;

  typedef enum logic [1:0] {
    CAFP_FLT_SINGLE = 2'b00,
    CAFP_FLT_DUAL   = 2'b01,
    CAFP_FLT_QUAD   = 2'b10,
    CAFP_FLT_CLOSED = 2'b11
  } cafp_flt_t;

  // Received frame header from the protocol engine
  typedef struct packed {
    logic [28:0] id;   // Standard id in [10:0]
    logic        ide;
    logic        rtr;
    logic        srr;
  } cafp_frame_t;
endpackage : cafp_pkg

// ==== logic/cafp_top.sv ====
// Notes on behaviour
// [R1] Compare id bits with pattern, skipping bits the mask marks don't care.
// [R2] Accepted frame sets rx_full and hit index; lowest filter wins.
// [R3] Single mode: one 32-bit filter, extended or standard layout.
// [R4] Dual mode: two 16-bit filters on leading id bits plus flags.
// [R5] Quad mode: four 8-bit filters on first eight standard id bits.
// [R6] Closed mode never loads the foreground buffer nor sets rx_full.
// [R7] Transmit request while any enabled buffer is empty.
// [R8] rx_full set and receive request right after a good frame.
// [R9] Wake request on bus activity only if sleep_ack and enable are 1.
// [R10] Warning flags when rx or tx error count reaches 96.
// [R11] Passive flags when rx or tx error count exceeds 127.
// [R12] Bus-off flag when tx error count exceeds 255.
// [R13] Requests stay high while any enabled flag stays set.
// [R14] Writing one clears that flag only; others stay.
// [R15] Clear is ignored while the setting condition still holds.
// [R16] Software avoids read-modify-write set instructions on flags.
// [R17] Four requests over eleven masked sources, plus global mask.
// [R18] Error counters are read only.
// [R19] Config, timing and filter writes only while soft reset is set.
// [R20] Transmit pin recessive in sleep, soft reset or power-down.
// [R21] Clocks stop except register access; all stop in power-down.
// [R22] Mode from cpu stop, sleep_ack and soft_reset_lock.
// [R23] Accepted frame with both buffers full is dropped with overrun.
// [R24] Background copies to foreground only while rx_full is clear.
// [R25] Hit index binary, stable until next accepted message.
`timescale 1ns/1ps
`include "cafp_defs.svh"

module cafp_top (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire cafp_pkg::cafp_frame_t rx_frame,
  input  wire logic               rx_frame_ok,
  input  wire logic [2:0]         tx_buf_empty,
  output logic      [2:0]         tx_sched,
  input  wire logic [8:0]         rx_err_cnt,
  input  wire logic [8:0]         tx_err_cnt,
  input  wire logic               sleep_ack,
  input  wire logic               cpu_stop,
  input  wire logic               cpu_int_mask,
  input  wire logic               can_rx,
  input  wire logic               engine_tx,
  output logic                    can_tx,
  output logic                    fg_copy,
  output logic                    core_clk_en,
  output logic                    reg_clk_en,
  output logic      [7:0]         module_ctrl_one,
  output logic      [7:0]         bit_timing_zero,
  output logic      [7:0]         bit_timing_one,
  output logic                    irq_wake,
  output logic                    irq_error,
  output logic                    irq_rx,
  output logic                    irq_tx
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                 soft_reset_lock_reg;
  logic [7:0]           ctrl1_reg;
  logic [7:0]           bt0_reg;
  logic [7:0]           bt1_reg;
  logic [7:0]           rx_flag_reg;
  logic [7:0]           rx_flag_next;
  logic [7:0]           rx_ien_reg;
  logic [2:0]           tx_ien_reg;
  logic [2:0]           tx_sched_reg;
  cafp_pkg::cafp_flt_t  flt_mode_reg;
  logic [1:0]           hit_reg;
  logic [1:0]           bg_hit_reg;
  logic                 bg_full_reg;
  logic [31:0]          id_accept_pattern;
  logic [31:0]          id_accept_mask;
  logic [31:0]          prdata_reg;
  logic [5:0]           cond_prev_reg;
  logic                 fg_copy_reg;
  logic [2:0]           rx_sync_reg;
  logic                 rx_level_reg;
  cafp_pkg::cafp_mode_t mode;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       wr_en      = psel & penable & pwrite;
  wire       setup_rd   = psel & ~penable & ~pwrite;
  wire       sel_ctrl0  = (paddr == `CAFP_OFF_CTRL0);
  wire       sel_ctrl1  = (paddr == `CAFP_OFF_CTRL1);
  wire       sel_bt0    = (paddr == `CAFP_OFF_BT0);
  wire       sel_bt1    = (paddr == `CAFP_OFF_BT1);
  wire       sel_rxflag = (paddr == `CAFP_OFF_RXFLAG);
  wire       sel_rxien  = (paddr == `CAFP_OFF_RXIEN);
  wire       sel_txflag = (paddr == `CAFP_OFF_TXFLAG);
  wire       sel_txien  = (paddr == `CAFP_OFF_TXIEN);
  wire       sel_afc    = (paddr == `CAFP_OFF_AFC);
  wire       sel_pat    = (paddr == `CAFP_OFF_PATTERN);
  wire       sel_mask   = (paddr == `CAFP_OFF_MASK);
  wire       sel_err    = (paddr == `CAFP_OFF_ERRCNT);
  wire       mapped     = sel_ctrl0 | sel_ctrl1 | sel_bt0 | sel_bt1 | sel_rxflag | sel_rxien
                        | sel_txflag | sel_txien | sel_afc | sel_pat | sel_mask | sel_err;
  // Locked registers accept writes only in soft reset
  wire       cfg_wr     = wr_en & soft_reset_lock_reg;  // [R19]
  wire [7:0] rx_w1c     = (wr_en & sel_rxflag) ? pwdata[7:0] : 8'h00;  // [R14]

  // Answer in the access phase; unmapped addresses get an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_reg;

  // ----------------------------------------------------------------
  // Mode selection and pin protection
  // ----------------------------------------------------------------
  // Stop wins, then soft reset, then sleep
  always_comb
  begin
    if (cpu_stop)
      mode = cafp_pkg::CAFP_MODE_PDOWN;  // [R22]
    else if (soft_reset_lock_reg)
      mode = cafp_pkg::CAFP_MODE_SOFT;   // [R22]
    else if (sleep_ack)
      mode = cafp_pkg::CAFP_MODE_SLEEP;  // [R22]
    else
      mode = cafp_pkg::CAFP_MODE_NORMAL; // [R22]
  end

  wire mode_normal = (mode == cafp_pkg::CAFP_MODE_NORMAL);
  wire mode_sleep  = (mode == cafp_pkg::CAFP_MODE_SLEEP);
  wire mode_pdown  = (mode == cafp_pkg::CAFP_MODE_PDOWN);

  // Recessive level outside normal mode
  assign can_tx      = mode_normal ? engine_tx : 1'b1;  // [R20]
  assign core_clk_en = mode_normal;                     // [R21]
  assign reg_clk_en  = ~mode_pdown;                     // [R21]

  // ----------------------------------------------------------------
  // Acceptance filter
  // ----------------------------------------------------------------
  // Message word laid out like the filter bank
  wire [31:0] ext_word = {rx_frame.id[28:18], rx_frame.srr, rx_frame.ide, rx_frame.id[17:15],
                          rx_frame.id[14:0], rx_frame.rtr};
  wire [31:0] std_word = {rx_frame.id[10:0], rx_frame.rtr, rx_frame.ide, 19'h0_0000};
  wire [31:0] msg_word = rx_frame.ide ? ext_word : std_word;
  wire [31:0] cmp_ok_32;
  wire [15:0] care16   = rx_frame.ide ? 16'hFFFF : 16'hFFF8;
  wire [31:0] care32   = rx_frame.ide ? 32'hFFFF_FFFF : 32'hFFF8_0000;
  wire [3:0]  hit_q;
  wire [1:0]  hit_d;
  logic [3:0] hit_vec;
  wire [1:0]  hit_idx;

  // Equal or don't care, bit by bit
  assign cmp_ok_32 = ~(msg_word ^ id_accept_pattern) | id_accept_mask;  // [R1]
  wire   hit_s     = &(cmp_ok_32 | ~care32);                           // [R3]

  // Dual halves: each half of the bank against the leading 16 bits
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_dual
      wire [15:0] ok_h = ~(msg_word[31:16] ^ id_accept_pattern[31-16*g -: 16])
                       | id_accept_mask[31-16*g -: 16];                 // [R1]
      assign hit_d[g] = &(ok_h | ~care16);                               // [R4]
    end
    // Quad bytes: each byte of the bank against the first eight id bits
    for (g = 0; g < 4; g++)
    begin : g_quad
      wire [7:0] ok_b = ~(msg_word[31:24] ^ id_accept_pattern[31-8*g -: 8])
                      | id_accept_mask[31-8*g -: 8];                    // [R1]
      assign hit_q[g] = &ok_b & ~rx_frame.ide;                            // [R5]
    end
  endgenerate

  // Hit vector per mode; closed mode gives none
  always_comb
  begin
    unique case (flt_mode_reg)
      cafp_pkg::CAFP_FLT_SINGLE: hit_vec = {3'b000, hit_s};
      cafp_pkg::CAFP_FLT_DUAL:   hit_vec = {2'b00, hit_d};
      cafp_pkg::CAFP_FLT_QUAD:   hit_vec = hit_q;
      cafp_pkg::CAFP_FLT_CLOSED: hit_vec = 4'h0;  // [R6]
    endcase
  end

  // Lowest matching filter, binary coded
  assign hit_idx = hit_vec[0] ? 2'h0 :
                   hit_vec[1] ? 2'h1 :
                   hit_vec[2] ? 2'h2 : 2'h3;     // [R2] [R25]

  // ----------------------------------------------------------------
  // Receive buffers
  // ----------------------------------------------------------------
  wire accept  = rx_frame_ok & mode_normal & (|hit_vec);
  wire overrun = accept & bg_full_reg & rx_flag_reg[`CAFP_RXF_FULL];       // [R23]
  // No copy in sleep; software clearing rx_full releases the foreground
  wire copy    = bg_full_reg & ~rx_flag_reg[`CAFP_RXF_FULL] & ~mode_sleep; // [R24]

  // ----------------------------------------------------------------
  // Error conditions and wake detection
  // ----------------------------------------------------------------
  wire [5:0] cond;
  assign cond[0] = (tx_err_cnt > `CAFP_BOFF_LIMIT);   // [R12]
  assign cond[1] = (tx_err_cnt > `CAFP_PASS_LIMIT);   // [R11]
  assign cond[2] = (rx_err_cnt > `CAFP_PASS_LIMIT);   // [R11]
  assign cond[3] = (tx_err_cnt >= `CAFP_WARN_LIMIT);  // [R10]
  assign cond[4] = (rx_err_cnt >= `CAFP_WARN_LIMIT);  // [R10]
  assign cond[5] = 1'b0;
  wire [5:0] cond_rise = cond & ~cond_prev_reg;

  // Dominant edge on the filtered receive line
  wire rx_agree   = (rx_sync_reg[1] == rx_sync_reg[2]);
  wire rx_fall    = rx_agree & rx_level_reg & ~rx_sync_reg[2];
  wire wake_event = rx_fall & (mode_sleep | mode_pdown) & sleep_ack; // [R9]

  // ----------------------------------------------------------------
  // Receiver flag register
  // ----------------------------------------------------------------
  wire [7:0] set_ev = {wake_event, cond_rise[4], cond_rise[3], cond_rise[2], cond_rise[1],
                       cond_rise[0], overrun, copy};                            // [R8]
  wire [7:0] hold   = {1'b0, cond[4], cond[3], cond[2], cond[1], cond[0], 2'b00};

  // Set beats clear; clear blocked while condition holds
  assign rx_flag_next = set_ev | (rx_flag_reg & ~(rx_w1c & ~hold)); // [R14] [R15]

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  wire [7:0] rx_pend = rx_flag_reg & rx_ien_reg;
  wire       gate    = ~cpu_int_mask;  // [R17]
  assign irq_wake  = gate & rx_pend[`CAFP_RXF_WAKE] & sleep_ack;     // [R9] [R13]
  assign irq_error = gate & (|rx_pend[6:1]);                           // [R13] [R17]
  assign irq_rx    = gate & rx_pend[`CAFP_RXF_FULL];                   // [R8] [R13]
  assign irq_tx    = gate & (|(tx_buf_empty & tx_ien_reg));            // [R7] [R13]

  assign tx_sched        = tx_sched_reg;
  assign fg_copy         = fg_copy_reg;
  assign module_ctrl_one = ctrl1_reg;
  assign bit_timing_zero = bt0_reg;
  assign bit_timing_one  = bt1_reg;

  // ----------------------------------------------------------------
  // Read mux, error counters visible but never written
  // ----------------------------------------------------------------
  wire [31:0] rd_afc = {26'h000_0000, flt_mode_reg, 2'b00, hit_reg};
  wire [31:0] rd_err = {7'h00, tx_err_cnt, 7'h00, rx_err_cnt};  // [R18]
  wire [31:0] rd_val =
    sel_ctrl0  ? {30'h0000_0000, sleep_ack, soft_reset_lock_reg} :
    sel_ctrl1  ? {24'h00_0000, ctrl1_reg} :
    sel_bt0    ? {24'h00_0000, bt0_reg} :
    sel_bt1    ? {24'h00_0000, bt1_reg} :
    sel_rxflag ? {24'h00_0000, rx_flag_reg} :
    sel_rxien  ? {24'h00_0000, rx_ien_reg} :
    sel_txflag ? {29'h0000_0000, tx_buf_empty} :
    sel_txien  ? {29'h0000_0000, tx_ien_reg} :
    sel_afc    ? rd_afc :
    sel_pat    ? id_accept_pattern :
    sel_mask   ? id_accept_mask :
    sel_err    ? rd_err : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus registers
  // ----------------------------------------------------------------
  // Control and enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_reset_lock_reg <= 1'b1;
      rx_ien_reg          <= `CAFP_RST_BYTE;
      tx_ien_reg          <= 3'b000;
      prdata_reg          <= `CAFP_RST_WORD;
      tx_sched_reg        <= 3'b000;
    end
    else
    begin
      if (wr_en & sel_ctrl0)
        soft_reset_lock_reg <= pwdata[`CAFP_CTRL0_SRL];
      if (wr_en & sel_rxien)
        rx_ien_reg <= pwdata[7:0];
      if (wr_en & sel_txien)
        tx_ien_reg <= pwdata[2:0];
      if (setup_rd)
        prdata_reg <= rd_val;
      tx_sched_reg <= (wr_en & sel_txflag) ? (pwdata[2:0] & tx_buf_empty) : 3'b000;
    end
  end

  // Locked configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1_reg         <= `CAFP_RST_BYTE;
      bt0_reg           <= `CAFP_RST_BYTE;
      bt1_reg           <= `CAFP_RST_BYTE;
      flt_mode_reg      <= cafp_pkg::CAFP_FLT_SINGLE;
      id_accept_pattern <= `CAFP_RST_WORD;
      id_accept_mask    <= `CAFP_RST_WORD;
    end
    else
    begin
      if (cfg_wr & sel_ctrl1)
        ctrl1_reg <= pwdata[7:0];             // [R19]
      if (cfg_wr & sel_bt0)
        bt0_reg <= pwdata[7:0];               // [R19]
      if (cfg_wr & sel_bt1)
        bt1_reg <= pwdata[7:0];               // [R19]
      if (cfg_wr & sel_afc)
        flt_mode_reg <= cafp_pkg::cafp_flt_t'(pwdata[`CAFP_AFC_MODE_LSB +: 2]);  // [R19]
      if (cfg_wr & sel_pat)
        id_accept_pattern <= pwdata;          // [R19]
      if (cfg_wr & sel_mask)
        id_accept_mask <= pwdata;             // [R19]
    end
  end

  // ----------------------------------------------------------------
  // Receive state, flags and synchroniser
  // ----------------------------------------------------------------
  // Buffer occupancy and hit index
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bg_full_reg <= 1'b0;
      bg_hit_reg  <= 2'b00;
      hit_reg     <= 2'b00;
      fg_copy_reg <= 1'b0;
    end
    else
    begin
      if (accept & ~overrun)
      begin
        bg_full_reg <= 1'b1;
        bg_hit_reg  <= hit_idx;
      end
      else if (copy)
        bg_full_reg <= 1'b0;
      if (copy)
        hit_reg <= bg_hit_reg;                // [R25]
      fg_copy_reg <= copy;
    end
  end

  // Flags and condition history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_flag_reg   <= `CAFP_RST_BYTE;
      cond_prev_reg <= 6'h00;
    end
    else
    begin
      rx_flag_reg   <= rx_flag_next;
      cond_prev_reg <= cond;
    end
  end

  // Three-stage sync of the bus line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_sync_reg  <= 3'b111;
      rx_level_reg <= 1'b1;
    end
    else
    begin
      rx_sync_reg <= {rx_sync_reg[1:0], can_rx};
      if (rx_agree)
        rx_level_reg <= rx_sync_reg[2];
    end
  end

endmodule : cafp_top

// ==== test/cafp_bus_node.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-side node: frame delivery and bus activity
// ----------------------------------------------------------------
module cafp_bus_node (
  input wire logic              pclk,
  output cafp_pkg::cafp_frame_t rx_frame,
  output logic                  rx_frame_ok,
  output logic                  can_rx
);
  // Idle bus is recessive
  initial
  begin
    rx_frame = '0;
    rx_frame_ok = 1'b0;
    can_rx = 1'b1;
  end

  // One good frame after end of frame, header scrambled after
  task automatic deliver(input cafp_pkg::cafp_frame_t f);
    @(posedge pclk);
    rx_frame <= f;
    rx_frame_ok <= 1'b1;
    @(posedge pclk);
    rx_frame <= ~f;
    rx_frame_ok <= 1'b0;
  endtask : deliver

  // Short dominant burst on the bus
  task automatic activity;
    @(posedge pclk);
    can_rx <= 1'b0;
    repeat (4) @(posedge pclk);
    can_rx <= 1'b1;
  endtask : activity
endmodule : cafp_bus_node

// ==== test/cafp_props.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module cafp_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [2:0]  tx_buf_empty,
  input wire logic [2:0]  tx_sched,
  input wire logic        sleep_ack,
  input wire logic        cpu_stop,
  input wire logic        cpu_int_mask,
  input wire logic        engine_tx,
  input wire logic        can_tx,
  input wire logic        fg_copy,
  input wire logic        core_clk_en,
  input wire logic        reg_clk_en,
  input wire logic [7:0]  bit_timing_zero,
  input wire logic        irq_wake,
  input wire logic        irq_error,
  input wire logic        irq_rx,
  input wire logic        irq_tx
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_recessive;
    !core_clk_en |-> can_tx;
  endproperty
  a_tx_recessive: assert property (p_tx_recessive)
    else $error("transmit pin driven while stopped");
  property p_tx_follow;
    core_clk_en |-> can_tx == engine_tx;
  endproperty
  a_tx_follow: assert property (p_tx_follow)
    else $error("transmit pin not following engine");
  property p_pdown;
    cpu_stop |-> !reg_clk_en && !core_clk_en;
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("clock running in power-down");
  property p_sleep;
    !cpu_stop && sleep_ack |-> !core_clk_en && reg_clk_en;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("wrong clocks in sleep");
  property p_gmask;
    cpu_int_mask |-> !(irq_wake || irq_error || irq_rx || irq_tx);
  endproperty
  a_gmask: assert property (p_gmask)
    else $error("request through global mask");
  property p_wake_gate;
    !sleep_ack |-> !irq_wake;
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("wake request without sleep ack");
  property p_tx_idle;
    tx_buf_empty == 3'h0 |-> !irq_tx;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("transmit request with no empty buffer");
  property p_sched;
    |tx_sched |-> $past(psel && penable && pwrite && paddr == 12'h018)
      && (tx_sched & ~$past(tx_buf_empty)) == 3'h0;
  endproperty
  a_sched: assert property (p_sched)
    else $error("schedule pulse without write");
  property p_lock;
    $changed(bit_timing_zero) |-> $past(psel && penable && pwrite
      && paddr == 12'h008 && !core_clk_en && reg_clk_en);
  endproperty
  a_lock: assert property (p_lock)
    else $error("timing changed while unlocked");

  // Main scenarios seen
  c_copy: cover property (fg_copy);
  c_wake: cover property (irq_wake);
  c_err: cover property (irq_error);
  c_tx: cover property (irq_tx);
endmodule : cafp_props

// ==== test/can_accept_filter_irq_power_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module can_accept_filter_irq_power_test;
  logic                  pclk = 1'b0;
  logic                  presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata;
  cafp_pkg::cafp_frame_t rx_frame;
  logic                  rx_frame_ok, can_rx, engine_tx, can_tx, sleep_ack, cpu_stop, cpu_int_mask;
  logic                  fg_copy, core_clk_en, reg_clk_en, irq_wake, irq_error, irq_rx, irq_tx;
  logic [2:0]            tx_buf_empty, tx_sched;
  logic [8:0]            rx_err_cnt, tx_err_cnt;
  logic [7:0]            bit_timing_zero;
  logic                  last_err;
  int                    fails = 0;
  int                    checks_done = 0;

  always #2.5 pclk = ~pclk;

  cafp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_frame, .rx_frame_ok, .tx_buf_empty, .tx_sched, .rx_err_cnt, .tx_err_cnt,
    .sleep_ack, .cpu_stop, .cpu_int_mask, .can_rx, .engine_tx, .can_tx, .fg_copy, .core_clk_en,
    .reg_clk_en, .module_ctrl_one(), .bit_timing_zero, .bit_timing_one(), .irq_wake, .irq_error,
    .irq_rx, .irq_tx);
  cafp_bus_node node (.pclk, .rx_frame, .rx_frame_ok, .can_rx);

  // ----------------------------------------------------------------
  // Bus and frame helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask : rd

  task automatic send(input logic [10:0] id);
    cafp_pkg::cafp_frame_t f;
    f = '0;
    f.id = {18'h0, id};
    node.deliver(f);
  endtask : send

  task automatic wrap_up;
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, engine_tx, sleep_ack, cpu_stop, cpu_int_mask} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_buf_empty = 3'h0;
    rx_err_cnt = 9'h000;
    tx_err_cnt = 9'h000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0000_0001);
    `CHK(last_err, 1'b0)
    `CHK(can_tx, 1'b1)
    wr(12'h008, 32'h0000_005A);
    `CHK(bit_timing_zero, 8'h5A)
    wr(12'h024, 32'h2460_0000);
    wr(12'h028, 32'h0007_FFFF);
    wr(12'h014, 32'h0000_0001);
    wr(12'h000, 32'h0000_0000);
    wr(12'h008, 32'h0000_00A5);
    `CHK(bit_timing_zero, 8'h5A)
    `CHK(can_tx, 1'b0)
    send(11'h124);
    rd(12'h010, 32'h0000_0000);
    send(11'h123);
    rd(12'h010, 32'h0000_0001);
    `CHK(irq_rx, 1'b1)
    rd(12'h020, 32'h0000_0000);
    send(11'h123);
    send(11'h123);
    rd(12'h010, 32'h0000_0003);
    wr(12'h010, 32'h0000_0003);
    rd(12'h010, 32'h0000_0001);
    wr(12'h010, 32'h0000_0001);
    rd(12'h010, 32'h0000_0000);
    // Quad filters: filters 1, 2 and 3 all match
    wr(12'h000, 32'h0000_0001);
    wr(12'h020, 32'h0000_0020);
    wr(12'h024, 32'h1124_2400);
    wr(12'h028, 32'h0000_00FF);
    wr(12'h000, 32'h0000_0000);
    send(11'h123);
    rd(12'h020, 32'h0000_0021);
    wr(12'h010, 32'h0000_0001);
    // Closed filter
    wr(12'h000, 32'h0000_0001);
    wr(12'h020, 32'h0000_0030);
    wr(12'h000, 32'h0000_0000);
    send(11'h123);
    rd(12'h010, 32'h0000_0000);
    rd(12'h020, 32'h0000_0031);
    // Error counters and flags
    @(posedge pclk);
    rx_err_cnt <= 9'h060;
    rd(12'h010, 32'h0000_0040);
    wr(12'h010, 32'h0000_0040);
    rd(12'h010, 32'h0000_0040);
    @(posedge pclk);
    rx_err_cnt <= 9'h080;
    tx_err_cnt <= 9'h100;
    rd(12'h010, 32'h0000_007C);
    rd(12'h02C, 32'h0100_0080);
    wr(12'h02C, 32'h0000_0000);
    rd(12'h02C, 32'h0100_0080);
    wr(12'h014, 32'h0000_0004);
    `CHK(irq_error, 1'b1)
    @(posedge pclk);
    cpu_int_mask <= 1'b1;
    rx_err_cnt <= 9'h000;
    tx_err_cnt <= 9'h000;
    #1;
    `CHK(irq_error, 1'b0)
    @(posedge pclk);
    cpu_int_mask <= 1'b0;
    wr(12'h010, 32'h0000_0004);
    rd(12'h010, 32'h0000_0078);
    `CHK(irq_error, 1'b0)
    wr(12'h010, 32'h0000_00FF);
    // Transmit buffers
    @(posedge pclk);
    tx_buf_empty <= 3'b010;
    wr(12'h01C, 32'h0000_0001);
    `CHK(irq_tx, 1'b0)
    wr(12'h01C, 32'h0000_0002);
    `CHK(irq_tx, 1'b1)
    rd(12'h018, 32'h0000_0002);
    wr(12'h018, 32'h0000_0002);
    `CHK(tx_sched, 3'h2)
    // Wake from sleep
    wr(12'h014, 32'h0000_0080);
    @(posedge pclk);
    sleep_ack <= 1'b1;
    node.activity();
    repeat (4) @(posedge pclk);
    rd(12'h010, 32'h0000_0080);
    `CHK(irq_wake, 1'b1)
    @(posedge pclk);
    sleep_ack <= 1'b0;
    wr(12'h010, 32'h0000_0080);
    @(posedge pclk);
    engine_tx <= 1'b1;
    rd(12'h040, 32'h0000_0000);
    `CHK(last_err, 1'b1)
    `CHK(can_tx, 1'b1)
    @(posedge pclk);
    cpu_stop <= 1'b1;
    engine_tx <= 1'b0;
    #1;
    `CHK(reg_clk_en, 1'b0)
    `CHK(can_tx, 1'b1)
    @(posedge pclk);
    cpu_stop <= 1'b0;
    @(posedge pclk);
    wrap_up();
  end
endmodule : can_accept_filter_irq_power_test

bind cafp_top cafp_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .tx_buf_empty,
  .tx_sched, .sleep_ack, .cpu_stop, .cpu_int_mask, .engine_tx, .can_tx, .fg_copy, .core_clk_en,
  .reg_clk_en, .bit_timing_zero, .irq_wake, .irq_error, .irq_rx, .irq_tx);
